// file: oag_pkg.sv
package oag_pkg;
	// addressing modes presented by the decoder
	typedef enum logic [2:0] {
		OAG_M_REG = 3'b000,
		OAG_M_IND = 3'b001,
		OAG_M_IOFF = 3'b010,
		OAG_M_DIR = 3'b011,
		OAG_M_IMM = 3'b100,
		OAG_M_BIT = 3'b101,
		OAG_M_BRS = 3'b110,
		OAG_M_BRL = 3'b111
	} oag_mode_t;
	// operand sizes
	typedef enum logic [1:0] {
		OAG_SZ_B = 2'b00,
		OAG_SZ_W = 2'b01,
		OAG_SZ_D = 2'b10
	} oag_size_t;
	// immediate widths
	typedef enum logic [1:0] {
		OAG_I4 = 2'b00,
		OAG_I5 = 2'b01,
		OAG_I8 = 2'b10,
		OAG_I16 = 2'b11
	} oag_imm_t;
	// result spaces
	typedef enum logic [1:0] {
		OAG_SP_REGF = 2'b00,
		OAG_SP_DATA = 2'b01,
		OAG_SP_SFR = 2'b10,
		OAG_SP_CODE = 2'b11
	} oag_space_t;
	// register map (byte addresses)
	localparam logic [11:0] OAG_A_CTRL = 12'h000;
	localparam logic [11:0] OAG_A_DSEG = 12'h004;
	localparam logic [11:0] OAG_A_ESEG = 12'h008;
	localparam logic [11:0] OAG_A_CSEG = 12'h00c;
	localparam logic [11:0] OAG_A_SSEL = 12'h010;
	localparam logic [11:0] OAG_A_STAT = 12'h014;
	localparam logic [11:0] OAG_A_PTR0 = 12'h020;
	localparam int OAG_PTR_N = 8;
	localparam int OAG_CTRL_PZ = 0;
	// address space constants
	localparam logic [15:0] OAG_SFR_BASE = 16'h0400;
	localparam logic [15:0] OAG_BIT_DBASE = 16'h0020;
	localparam logic [9:0] OAG_BIT_RF_TOP = 10'h0ff;
	localparam logic [9:0] OAG_BIT_DM_TOP = 10'h1ff;
	localparam logic [7:0] OAG_REGF_BYTES = 8'h20;
	localparam logic [1:0] OAG_RESP_OK = 2'b00;
	localparam logic [1:0] OAG_RESP_SLV = 2'b10;
endpackage

// file: oag_ptr_mem.sv
// eight pointer words, registered read port, one write port
module oag_ptr_mem #(
	parameter int N = 8,
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [$clog2(N)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [$clog2(N)-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_r [N];
	// storage; reset clears so a first read is defined
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < N; i++) mem_r[i] <= '0;
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end
	// registered read
	always_ff @(posedge aclk) begin
		if (!aresetn) rdata <= '0;
		else rdata <= mem_r[raddr];
	end
endmodule

// file: oag_axil_slave.sv
// minimal axi4-lite slave: accepts aw and w in either order
module oag_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic wr_en,
	output logic [11:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [11:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	import oag_pkg::*;
	logic aw_held_r, w_held_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	wire aw_take = s_awvalid && s_awready;
	wire w_take = s_wvalid && s_wready;
	wire both = (aw_held_r || aw_take) && (w_held_r || w_take);
	assign wr_en = both && !s_bvalid;
	assign wr_addr = aw_held_r ? awaddr_r : s_awaddr;
	assign wr_data = w_held_r ? wdata_r : s_wdata;
	assign wr_strb = w_held_r ? wstrb_r : s_wstrb;
	assign s_awready = !aw_held_r && !s_bvalid;
	assign s_wready = !w_held_r && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign rd_addr = s_araddr;
	// write channel holding and response; back to back is stalled by bvalid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= OAG_RESP_OK;
		end else begin
			if (wr_en) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_ok ? OAG_RESP_OK : OAG_RESP_SLV;
			end else begin
				if (aw_take) aw_held_r <= 1'b1;
				if (w_take) w_held_r <= 1'b1;
				if (s_bvalid && s_bready) s_bvalid <= 1'b0;
			end
			if (aw_take) awaddr_r <= s_awaddr;
			if (w_take) wdata_r <= s_wdata;
			if (w_take) wstrb_r <= s_wstrb;
		end
	end
	// read channel: one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= OAG_RESP_OK;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata <= rd_ok ? rd_data : 32'h0000_0000;
			s_rresp <= rd_ok ? OAG_RESP_OK : OAG_RESP_SLV;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
endmodule

// file: oag_top.sv
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01: register file reached as byte, word, dword or bit; upper 8 words not bytes.
// R02: indirect address comes from one of eight pointer registers.
// R03: ssel bit per pointer picks data or extra segment, pc or code seg.
// R04: odd word address is forced even by clearing bit 0.
// R05: indirect with offset add_short_op signed 8 or 16 bit displacement to pointer.
// R06: direct uses 10-bit field, low 1K, always data segment.
// R07: upper-half direct values select sfr space 400h to 7FFh.
// R08: immediates 4/5, 8, 16 bit; short 4-bit ones sign extend.
// R09: bit field decodes to register file, data memory or sfr bits.
// R10: data bits map to bytes 20-3Fh, sfr bits to 400-43Fh.
// R11: branch, jump and call targets are always even.
// R12: short displacement is signed word count doubled to 9-bit bytes.
// R13: long displacement is signed word count doubled to 17-bit bytes.
// R14: relative base is address of the following instruction.
// R15: an odd following address is forced even before the add.
// R16: bcd is byte sized only; negatives are two's complement.
// R17: double word occupies two contiguous words.
// R18: effective address is segment byte over 16-bit offset.
// R19: page zero mode applies no segment, 16-bit addresses only.
// R20: pointer plus displacement wraps within the 64K segment.
// R21: word access to data or sfr ignores address bit 0.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
module oag_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic req_valid,
	input wire oag_pkg::oag_mode_t req_mode,
	input wire oag_pkg::oag_size_t req_size,
	input wire logic req_code,
	input wire logic [3:0] req_reg,
	input wire logic [15:0] req_field,
	input wire logic req_off16,
	input wire oag_pkg::oag_imm_t req_imm_w,
	input wire logic [23:0] req_pc_next,
	output logic res_valid,
	output logic [23:0] res_addr,
	output oag_pkg::oag_space_t res_space,
	output logic [2:0] res_bit,
	output logic [15:0] res_imm,
	output logic res_err
);
	import oag_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] dseg_r, eseg_r, cseg_r, ssel_r;
	logic pz_r;
	logic [7:0] err_cnt_r;
	logic wr_en, wr_ok, rd_ok;
	logic [11:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic [15:0] ptr_q;
	wire wr_ptr = wr_addr[11:5] == OAG_A_PTR0[11:5];
	wire rd_ptr = rd_addr[11:5] == OAG_A_PTR0[11:5];
	wire wr_ctl = wr_addr == OAG_A_CTRL;
	wire wr_ds = wr_addr == OAG_A_DSEG;
	wire wr_es = wr_addr == OAG_A_ESEG;
	wire wr_cs = wr_addr == OAG_A_CSEG;
	wire wr_ss = wr_addr == OAG_A_SSEL;
	assign wr_ok = wr_ctl || wr_ds || wr_es || wr_cs || wr_ss || wr_ptr;
	// pointer words read back through the same memory only for the core
	assign rd_ok = rd_addr == OAG_A_CTRL || rd_addr == OAG_A_DSEG ||
		rd_addr == OAG_A_ESEG || rd_addr == OAG_A_CSEG ||
		rd_addr == OAG_A_SSEL || rd_addr == OAG_A_STAT;
	assign rd_data = rd_addr == OAG_A_CTRL ? {31'h0, pz_r} :
		rd_addr == OAG_A_DSEG ? {24'h0, dseg_r} :
		rd_addr == OAG_A_ESEG ? {24'h0, eseg_r} :
		rd_addr == OAG_A_CSEG ? {24'h0, cseg_r} :
		rd_addr == OAG_A_SSEL ? {24'h0, ssel_r} :
		rd_addr == OAG_A_STAT ? {24'h0, err_cnt_r} : 32'h0;

	oag_axil_slave u_bus (
		.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_strb(wr_strb), .wr_ok(wr_ok), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_ok(rd_ok)
	);

	// control registers; only byte lane 0 carries data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dseg_r <= 8'h00;
			eseg_r <= 8'h00;
			cseg_r <= 8'h00;
			ssel_r <= 8'h00;
			pz_r <= 1'b0;
		end else if (wr_en && wr_strb[0]) begin
			if (wr_ds) dseg_r <= wr_data[7:0];
			if (wr_es) eseg_r <= wr_data[7:0];
			if (wr_cs) cseg_r <= wr_data[7:0];
			if (wr_ss) ssel_r <= wr_data[7:0];
			if (wr_ctl) pz_r <= wr_data[OAG_CTRL_PZ];
		end
	end

	// pointer select is taken one cycle early so registered read lines up
	wire ptr_we = wr_en && wr_ptr && (&wr_strb[1:0]);
	oag_ptr_mem #(.N(OAG_PTR_N), .W(16)) u_ptr (
		.aclk(aclk), .aresetn(aresetn),
		.we(ptr_we), .waddr(wr_addr[4:2]), .wdata(wr_data[15:0]),
		.raddr(req_reg[2:0]), .rdata(ptr_q)
	);

	////////////////////////////////////////////////////////////////////////
	// request stage 1: hold request while the pointer read completes
	logic s1_v_r;
	oag_mode_t s1_mode_r;
	oag_size_t s1_size_r;
	logic s1_code_r, s1_off16_r;
	logic [3:0] s1_reg_r;
	logic [15:0] s1_field_r;
	oag_imm_t s1_imm_r;
	logic [23:0] s1_pc_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_v_r <= 1'b0;
			s1_mode_r <= OAG_M_REG;
			s1_size_r <= OAG_SZ_B;
			s1_code_r <= 1'b0;
			s1_off16_r <= 1'b0;
			s1_reg_r <= 4'h0;
			s1_field_r <= 16'h0000;
			s1_imm_r <= OAG_I4;
			s1_pc_r <= 24'h000000;
		end else begin
			s1_v_r <= req_valid;
			s1_mode_r <= req_mode;
			s1_size_r <= req_size;
			s1_code_r <= req_code;
			s1_off16_r <= req_off16;
			s1_reg_r <= req_reg;
			s1_field_r <= req_field;
			s1_imm_r <= req_imm_w;
			s1_pc_r <= req_pc_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address formation
	// R03: segment select
	wire sel_bit = ssel_r[s1_reg_r[2:0]];
	wire [7:0] seg_ind = s1_code_r ? (sel_bit ? cseg_r : s1_pc_r[23:16])
		: (sel_bit ? eseg_r : dseg_r);
	// R05: signed displacement
	wire [15:0] disp = s1_off16_r ? s1_field_r :
		{{8{s1_field_r[7]}}, s1_field_r[7:0]};
	// R20: 16-bit wrap, no carry out
	wire [15:0] ind_sum = ptr_q + disp;
	// R02: plain indirect uses pointer
	wire [15:0] ind_off = s1_mode_r == OAG_M_IOFF ? ind_sum : ptr_q;
	// R06 R07: direct field upper half is sfr
	wire dir_sfr = s1_field_r[10];
	wire [15:0] dir_off = {6'h00, s1_field_r[9:0]} |
		(dir_sfr ? OAG_SFR_BASE : 16'h0000);
	// R09: bit space decode
	wire [9:0] bfield = s1_field_r[9:0];
	wire bit_rf = bfield <= OAG_BIT_RF_TOP;
	wire bit_dm = !bit_rf && bfield <= OAG_BIT_DM_TOP;
	// R10: byte of the addressed bit
	wire [15:0] bit_off = bit_rf ? {11'h000, bfield[7:3]} :
		bit_dm ? OAG_BIT_DBASE + {11'h000, bfield[7:3]} :
		OAG_SFR_BASE + {10'h000, bfield[8:3]};
	// R14 R15: following address forced even
	wire [23:0] pc_even = {s1_pc_r[23:1], 1'b0};
	// R12: short disp doubled to 9 bits
	wire [16:0] bdisp_s = {{8{s1_field_r[7]}}, s1_field_r[7:0], 1'b0};
	// R13: long disp doubled to 17 bits
	wire [16:0] bdisp_l = {s1_field_r, 1'b0};
	wire [16:0] bdisp = s1_mode_r == OAG_M_BRS ? bdisp_s : bdisp_l;
	// branch target stays within the 64K code page
	wire [15:0] br_sum = pc_even[15:0] + bdisp[15:0];
	// R11: target always even
	wire [23:0] br_tgt = {pc_even[23:16], br_sum[15:1], 1'b0};
	// R08: immediate selection and sign extension of the 4-bit form
	wire [15:0] imm4 = {{12{s1_field_r[3]}}, s1_field_r[3:0]};
	wire [15:0] imm4s = s1_size_r == OAG_SZ_B ? {8'h00, imm4[7:0]} : imm4;
	wire [15:0] imm_v = s1_imm_r == OAG_I4 ? imm4s :
		s1_imm_r == OAG_I5 ? {11'h000, s1_field_r[4:0]} :
		s1_imm_r == OAG_I8 ? {8'h00, s1_field_r[7:0]} : s1_field_r;
	// R01: byte access to upper eight word registers is refused
	wire reg_err = s1_mode_r == OAG_M_REG && s1_size_r == OAG_SZ_B &&
		s1_reg_r[3];
	// R16: operand size tag, dword needs even register
	wire dw_err = s1_mode_r == OAG_M_REG && s1_size_r == OAG_SZ_D &&
		s1_reg_r[0];
	wire sz_err = s1_size_r == 2'b11;

	logic [15:0] off_raw;
	logic [7:0] seg_sel;
	oag_space_t space_sel;
	// mode mux
	always_comb begin
		off_raw = 16'h0000;
		seg_sel = dseg_r;
		space_sel = OAG_SP_DATA;
		unique case (s1_mode_r)
			OAG_M_REG: begin
				// R17: dword as two words at word address
				off_raw = {11'h000, s1_reg_r, 1'b0};
				space_sel = OAG_SP_REGF;
			end
			OAG_M_IND, OAG_M_IOFF: begin
				off_raw = ind_off;
				seg_sel = seg_ind;
				space_sel = s1_code_r ? OAG_SP_CODE : OAG_SP_DATA;
			end
			OAG_M_DIR: begin
				off_raw = dir_off;
				space_sel = dir_sfr ? OAG_SP_SFR : OAG_SP_DATA;
			end
			OAG_M_IMM: begin
				space_sel = OAG_SP_REGF;
			end
			OAG_M_BIT: begin
				off_raw = bit_off;
				space_sel = bit_rf ? OAG_SP_REGF :
					bit_dm ? OAG_SP_DATA : OAG_SP_SFR;
			end
			OAG_M_BRS, OAG_M_BRL: begin
				off_raw = br_tgt[15:0];
				seg_sel = br_tgt[23:16];
				space_sel = OAG_SP_CODE;
			end
		endcase
	end
	// R04 R21: word and dword drop bit 0 except for the bit form
	wire force_even = s1_size_r != OAG_SZ_B && s1_mode_r != OAG_M_BIT;
	wire [15:0] off_fin = {off_raw[15:1], off_raw[0] & !force_even};
	// sfr and register space carry no segment
	wire seg_none = space_sel == OAG_SP_SFR || space_sel == OAG_SP_REGF;
	// R18 R19: segment above offset unless page zero
	wire [23:0] ea = {(pz_r || seg_none) ? 8'h00 : seg_sel, off_fin};

	// result registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_valid <= 1'b0;
			res_addr <= 24'h000000;
			res_space <= OAG_SP_REGF;
			res_bit <= 3'h0;
			res_imm <= 16'h0000;
			res_err <= 1'b0;
		end else begin
			res_valid <= s1_v_r;
			res_addr <= ea;
			res_space <= space_sel;
			res_bit <= bfield[2:0];
			res_imm <= imm_v;
			res_err <= s1_v_r && (reg_err || dw_err || sz_err);
		end
	end
	// error counter for software visibility
	always_ff @(posedge aclk) begin
		if (!aresetn) err_cnt_r <= 8'h00;
		else if (s1_v_r && (reg_err || dw_err || sz_err) && ~&err_cnt_r)
			err_cnt_r <= err_cnt_r + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_pz;
		@(posedge aclk) disable iff (!aresetn)
		res_valid && $past(pz_r) |-> res_addr[23:16] == 8'h00;
	endproperty
	a_pz: assert property (p_pz) else $error("page zero seg"); // R19
	property p_even_br;
		@(posedge aclk) disable iff (!aresetn)
		res_valid && res_space == OAG_SP_CODE &&
		$past(s1_mode_r == OAG_M_BRS || s1_mode_r == OAG_M_BRL)
		|-> !res_addr[0];
	endproperty
	a_even_br: assert property (p_even_br) else $error("odd target"); // R11
	property p_lat;
		@(posedge aclk) disable iff (!aresetn)
		req_valid |-> ##2 res_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("result latency"); // result two cycles after each request
	property p_word_even;
		@(posedge aclk) disable iff (!aresetn)
		s1_v_r && force_even |=> !res_addr[0];
	endproperty
	a_word_even: assert property (p_word_even) else $error("odd word"); // R04
	property p_sfr;
		@(posedge aclk) disable iff (!aresetn)
		s1_v_r && s1_mode_r == OAG_M_DIR && dir_sfr |=>
		res_space == OAG_SP_SFR && res_addr[15:10] == 6'h01;
	endproperty
	a_sfr: assert property (p_sfr) else $error("sfr decode"); // R07
	property p_bitdm;
		@(posedge aclk) disable iff (!aresetn)
		s1_v_r && s1_mode_r == OAG_M_BIT && bit_dm |=>
		res_addr[15:0] >= 16'h0020 && res_addr[15:0] <= 16'h003f;
	endproperty
	a_bitdm: assert property (p_bitdm) else $error("bit data map"); // R10
	property p_byte_reg;
		@(posedge aclk) disable iff (!aresetn)
		s1_v_r && reg_err |=> res_err;
	endproperty
	a_byte_reg: assert property (p_byte_reg) else $error("byte reg"); // R01
	property p_dir_ds;
		@(posedge aclk) disable iff (!aresetn)
		s1_v_r && s1_mode_r == OAG_M_DIR && !dir_sfr && !pz_r |=>
		res_addr[23:16] == $past(dseg_r);
	endproperty
	a_dir_ds: assert property (p_dir_ds) else $error("direct seg"); // R06
	c_br: cover property (@(posedge aclk) res_valid && res_space == OAG_SP_CODE);
	c_sfr: cover property (@(posedge aclk) res_valid && res_space == OAG_SP_SFR);
	c_err: cover property (@(posedge aclk) res_err);
endmodule

// file: oag_dec_model.sv
////////////////////////////////////////////////////////////////////////////
// decoder stand-in: issues operand requests, queues the results
module oag_dec_model (
	input wire logic aclk,
	output logic req_valid,
	output oag_pkg::oag_mode_t req_mode,
	output oag_pkg::oag_size_t req_size,
	output logic req_code,
	output logic [3:0] req_reg,
	output logic [15:0] req_field,
	output logic req_off16,
	output oag_pkg::oag_imm_t req_imm_w,
	output logic [23:0] req_pc_next,
	input wire logic res_valid,
	input wire logic [23:0] res_addr,
	input wire oag_pkg::oag_space_t res_space,
	input wire logic [2:0] res_bit,
	input wire logic [15:0] res_imm,
	input wire logic res_err
);
	timeunit 1ns;
	timeprecision 1ps;
	import oag_pkg::*;
	logic [45:0] q[$];
	// quiet request lines from time zero
	initial begin
		req_valid = 1'b0;
		req_mode = OAG_M_REG;
		req_size = OAG_SZ_B;
		req_code = 1'b0;
		req_reg = 4'h0;
		req_field = 16'h0;
		req_off16 = 1'b0;
		req_imm_w = OAG_I4;
		req_pc_next = 24'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// valid stays up between calls so requests can go back to back
	task automatic send(input oag_mode_t m, input oag_size_t s,
		input logic c, input logic [3:0] r, input logic [15:0] f,
		input logic o = 1'b0, input oag_imm_t w = OAG_I4,
		input logic [23:0] pc = 24'h0);
		@(posedge aclk);
		req_valid <= 1'b1;
		req_mode <= m;
		req_size <= s;
		req_code <= c;
		req_reg <= r;
		req_field <= f;
		req_off16 <= o;
		req_imm_w <= w;
		req_pc_next <= pc;
	endtask
	// idle fields are scrambled so a stale operand cannot look right
	task automatic idle();
		@(posedge aclk);
		req_valid <= 1'b0;
		req_reg <= ~req_reg;
		req_field <= ~req_field;
		req_pc_next <= ~req_pc_next;
	endtask
	// results kept in arrival order
	always @(posedge aclk) begin
		if (res_valid === 1'b1)
			q.push_back({res_err, res_space, res_bit, res_imm, res_addr});
	end
endmodule

// file: oag_top_tb_top.sv
module oag_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import oag_pkg::*;
	logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
	logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	logic [11:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [3:0] s_wstrb, req_reg;
	logic [1:0] s_bresp, s_rresp, br, rr, rs;
	logic req_valid, req_code, req_off16, res_valid, res_err, re;
	oag_mode_t req_mode;
	oag_size_t req_size;
	oag_imm_t req_imm_w;
	oag_space_t res_space;
	logic [15:0] req_field, res_imm, ri;
	logic [23:0] req_pc_next, res_addr, ra;
	logic [2:0] res_bit, rb;
	int fails, num_checks;
	oag_top uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .req_valid, .req_mode, .req_size, .req_code,
		.req_reg, .req_field, .req_off16, .req_imm_w, .req_pc_next,
		.res_valid, .res_addr, .res_space, .res_bit, .res_imm, .res_err);
	oag_dec_model dm (.aclk, .req_valid, .req_mode, .req_size, .req_code,
		.req_reg, .req_field, .req_off16, .req_imm_w, .req_pc_next,
		.res_valid, .res_addr, .res_space, .res_bit, .res_imm, .res_err);
	// free running 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cka(input logic [23:0] ea, input logic [1:0] es);
		chk(32'(ra), 32'(ea));
		chk(32'(rs), 32'(es));
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_awready === 1'b1)
				s_awvalid <= 1'b0;
			if (s_wready === 1'b1)
				s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1 && n < 40);
		// a write that never answers counts against the run
		if (s_bvalid !== 1'b1)
			chk(32'h0, 32'h1);
		br = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_arready === 1'b1)
				s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1 && n < 40);
		// a read that never answers counts against the run
		if (s_rvalid !== 1'b1)
			chk(32'h0, 32'h1);
		rd = s_rdata;
		rr = s_rresp;
		s_rready <= 1'b0;
	endtask
	// bounded wait for the next queued result
	task automatic pull();
		int n;
		n = 0;
		while (dm.q.size() == 0 && n < 10) begin
			@(posedge aclk);
			n++;
		end
		if (dm.q.size() == 0)
			chk(32'h0, 32'h1);
		else
			{re, rs, rb, ri, ra} = dm.q.pop_front();
	endtask
	task automatic get(input oag_mode_t m, input oag_size_t s,
		input logic c, input logic [3:0] r, input logic [15:0] f,
		input logic o = 1'b0, input oag_imm_t w = OAG_I4,
		input logic [23:0] pc = 24'h0);
		dm.send(m, s, c, r, f, o, w, pc);
		dm.idle();
		pull();
	endtask
	task automatic gb(input logic [15:0] f, input logic [23:0] pc,
		input logic l, input logic [23:0] ea);
		get(l ? OAG_M_BRL : OAG_M_BRS, OAG_SZ_W, 1'b0, 4'h0, f, 1'b0,
			OAG_I4, pc);
		cka(ea, OAG_SP_CODE);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		axr(OAG_A_CTRL);
		chk(rd, 32'h0);
		axr(OAG_A_STAT);
		chk(rd, 32'h0);
		axw(OAG_A_DSEG, 32'h21);
		axw(OAG_A_ESEG, 32'h43);
		axw(OAG_A_CSEG, 32'h65);
		axw(OAG_A_SSEL, 32'h5a);
		chk(32'(br), 32'(OAG_RESP_OK));
		axr(OAG_A_ESEG);
		chk(rd, 32'h43);
		axr(OAG_A_PTR0);
		chk(32'(rr), 32'(OAG_RESP_SLV));
		axr(12'h040);
		chk(32'(rr), 32'(OAG_RESP_SLV));
		chk(rd, 32'h0);
		axw(12'h044, 32'h1);
		chk(32'(br), 32'(OAG_RESP_SLV));
		$display("test regs done");
	endtask
	// pointers hold odd values; select bits 1,3,4,6 pick the second segment
	task automatic t_ind();
		logic [7:0] sg;
		for (int n = 0; n < 8; n++)
			axw(OAG_A_PTR0 + 12'(4 * n), {16'h0, 4'(n), 12'h235});
		for (int n = 0; n < 8; n++) begin
			sg = (8'h5a >> n) & 8'h1 ? 8'h43 : 8'h21;
			get(OAG_M_IND, OAG_SZ_W, 1'b0, 4'(n), 16'h0);
			cka({sg, 4'(n), 12'h234}, OAG_SP_DATA);
			sg = (8'h5a >> n) & 8'h1 ? 8'h65 : 8'h7a;
			get(OAG_M_IND, OAG_SZ_B, 1'b1, 4'(n), 16'h0, 1'b0, OAG_I4,
				24'h7a0013);
			chk(32'(ra), {8'h0, sg, 4'(n), 12'h235});
		end
		get(OAG_M_IND, OAG_SZ_B, 1'b0, 4'h3, 16'h0);
		cka(24'h433235, OAG_SP_DATA);
		$display("test indirect done");
	endtask
	task automatic t_ioff();
		axw(OAG_A_PTR0 + 12'h01c, 32'h0000fff0);
		get(OAG_M_IOFF, OAG_SZ_W, 1'b0, 4'h1, 16'h00f0);
		cka(24'h431224, OAG_SP_DATA);
		get(OAG_M_IOFF, OAG_SZ_W, 1'b0, 4'h6, 16'hab30);
		cka(24'h436264, OAG_SP_DATA);
		get(OAG_M_IOFF, OAG_SZ_B, 1'b0, 4'h7, 16'h0025, 1'b1);
		cka(24'h210015, OAG_SP_DATA);
		$display("test offset done");
	endtask
	task automatic t_dir();
		get(OAG_M_DIR, OAG_SZ_W, 1'b0, 4'h0, 16'h0200);
		cka(24'h210200, OAG_SP_DATA);
		get(OAG_M_DIR, OAG_SZ_W, 1'b0, 4'h0, 16'h03ff);
		cka(24'h2103fe, OAG_SP_DATA);
		dm.send(OAG_M_DIR, OAG_SZ_W, 1'b0, 4'h0, 16'h0010);
		dm.send(OAG_M_DIR, OAG_SZ_B, 1'b0, 4'h0, 16'h0406);
		dm.idle();
		pull();
		cka(24'h210010, OAG_SP_DATA);
		pull();
		cka(24'h000406, OAG_SP_SFR);
		$display("test direct done");
	endtask
	task automatic t_imm();
		get(OAG_M_IMM, OAG_SZ_W, 1'b0, 4'h0, 16'hfff5, 1'b0, OAG_I4);
		chk(32'(ri), 32'h0005);
		get(OAG_M_IMM, OAG_SZ_W, 1'b0, 4'h0, 16'h000b, 1'b0, OAG_I4);
		chk(32'(ri), 32'hfffb);
		get(OAG_M_IMM, OAG_SZ_B, 1'b0, 4'h0, 16'h0009, 1'b0, OAG_I4);
		chk(32'(ri[7:0]), 32'hf9);
		get(OAG_M_IMM, OAG_SZ_W, 1'b0, 4'h0, 16'h00fb, 1'b0, OAG_I5);
		chk(32'(ri), 32'h001b);
		get(OAG_M_IMM, OAG_SZ_W, 1'b0, 4'h0, 16'h12b9, 1'b0, OAG_I8);
		chk(32'(ri[7:0]), 32'hb9);
		get(OAG_M_IMM, OAG_SZ_W, 1'b0, 4'h0, 16'ha5c3, 1'b0, OAG_I16);
		chk(32'(ri), 32'ha5c3);
		$display("test immediate done");
	endtask
	task automatic t_bit();
		get(OAG_M_BIT, OAG_SZ_B, 1'b0, 4'h0, 16'h00a5);
		chk(32'(rs), 32'(OAG_SP_REGF));
		chk(32'(rb), 32'h5);
		cka(24'h000014, OAG_SP_REGF);
		get(OAG_M_BIT, OAG_SZ_B, 1'b0, 4'h0, 16'h01a5);
		cka(24'h210034, OAG_SP_DATA);
		get(OAG_M_BIT, OAG_SZ_B, 1'b0, 4'h0, 16'h03ff);
		cka(24'h00043f, OAG_SP_SFR);
		chk(32'(rb), 32'h7);
		get(OAG_M_BIT, OAG_SZ_B, 1'b0, 4'h0, 16'h0202);
		cka(24'h000400, OAG_SP_SFR);
		$display("test bit done");
	endtask
	// odd following address forced even before the doubled displacement
	task automatic t_br();
		gb(16'h007f, 24'h120101, 1'b0, 24'h1201fe);
		gb(16'h5580, 24'h120101, 1'b0, 24'h120000);
		gb(16'h0001, 24'h003456, 1'b0, 24'h003458);
		gb(16'h8000, 24'h120101, 1'b1, 24'h120100);
		gb(16'h7fff, 24'h120003, 1'b1, 24'h120000);
		$display("test branch done");
	endtask
	task automatic t_pz();
		axw(OAG_A_CTRL, 32'h1);
		axr(OAG_A_CTRL);
		chk(rd, 32'h1);
		get(OAG_M_IND, OAG_SZ_W, 1'b0, 4'h1, 16'h0);
		cka(24'h001234, OAG_SP_DATA);
		get(OAG_M_DIR, OAG_SZ_W, 1'b0, 4'h0, 16'h0200);
		cka(24'h000200, OAG_SP_DATA);
		axw(OAG_A_CTRL, 32'h0);
		get(OAG_M_IND, OAG_SZ_W, 1'b0, 4'h1, 16'h0);
		cka(24'h431234, OAG_SP_DATA);
		$display("test page zero done");
	endtask
	// three refused forms, then the error count must read three
	task automatic t_err();
		get(OAG_M_REG, OAG_SZ_B, 1'b0, 4'h9, 16'h0);
		chk(32'(re), 32'h1);
		get(OAG_M_REG, OAG_SZ_D, 1'b0, 4'h3, 16'h0);
		chk(32'(re), 32'h1);
		get(OAG_M_REG, oag_size_t'(2'b11), 1'b0, 4'h2, 16'h0);
		chk(32'(re), 32'h1);
		get(OAG_M_REG, OAG_SZ_W, 1'b0, 4'h9, 16'h0);
		chk(32'(re), 32'h0);
		cka(24'h000012, OAG_SP_REGF);
		get(OAG_M_REG, OAG_SZ_B, 1'b0, 4'h7, 16'h0);
		chk(32'(re), 32'h0);
		axr(OAG_A_STAT);
		chk(rd, 32'h3);
		$display("test errors done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		fails = 0;
		num_checks = 0;
		aresetn = 1'b0;
		s_awaddr = 12'h0;
		s_awvalid = 1'b0;
		s_wdata = 32'h0;
		s_wstrb = 4'hf;
		s_wvalid = 1'b0;
		s_bready = 1'b0;
		s_araddr = 12'h0;
		s_arvalid = 1'b0;
		s_rready = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_ind();
		t_ioff();
		t_dir();
		t_imm();
		t_bit();
		t_br();
		t_pz();
		t_err();
		print_verdict();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		fails++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule
